// *** include/fe_cfg_pkg.sv ***
`default_nettype none
package fe_cfg_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_PD_LOW = 6'h01;
   localparam logic [5:0] IDX_PD_HIGH = 6'h02;
   localparam logic [5:0] IDX_CLK_SRC = 6'h03;
   localparam logic [5:0] IDX_FILT_SEL = 6'h04;
   localparam logic [5:0] IDX_TUNE = 6'h05;
   localparam logic [5:0] IDX_GAIN = 6'h06;
   // Reset values
   localparam logic [7:0] RST_PD_LOW = 8'h00;
   localparam logic [7:0] RST_PD_HIGH = 8'h9f;
   localparam logic [7:0] RST_CLK_SRC = 8'h02;
   localparam logic [7:0] RST_FILT_SEL = 8'h01;
   localparam logic [7:0] RST_TUNE = 8'h80;
   localparam logic [7:0] RST_GAIN = 8'h00;
   // Power-down mask fields
   localparam int PD_LPF = 0;
   localparam int PD_ADC = 1;
   localparam int PD_REF = 2;
   localparam int PD_INTERP = 3;
   localparam int PD_DAC = 4;
   localparam int PD_TX_SYN = 5;
   localparam int PD_RX_SYN = 6;
   localparam int PD_REG = 7;
   // Clock source fields
   localparam int CS_L_LO = 0;
   localparam int CS_N_LO = 2;
   localparam int CS_M_LO = 4;
   localparam int CS_ADC_SRC = 6;
   localparam int CS_NEG_EDGE = 7;
   // Filter select fields
   localparam int FS_BYPASS = 0;
   localparam int FS_ONE_POLE = 1;
   localparam int FS_WIDE = 2;
   localparam int FS_FAST_ADC = 3;
   localparam int FS_HPF_BYP = 4;
   localparam int FS_OFS_CORR = 5;
   localparam int FS_CAL_BUSY = 6;
   localparam int FS_CAL_DIS = 7;
   // Gain fields and map
   localparam int GAIN_SRC = 5;
   localparam logic [4:0] GAIN_MAX_CODE = 5'h15;
   localparam logic signed [6:0] GAIN_WIDE_CAP_DB = 7'sd30;
   // Cutoff numerators and target offset
   localparam logic [7:0] CUT_NUM_LOW = 8'h40;
   localparam logic [7:0] CUT_NUM_HIGH = 8'h9e;
   localparam logic [8:0] TARGET_OFS = 9'h040;
   // Timing
   localparam longint CLK_PERIOD_NS = 4;
   localparam longint CAL_TIME_MS = 500;
   localparam longint CAL_PERIOD_MS = 2000;
   localparam longint CAL_CYCLES = CAL_TIME_MS * 64'd1000000 / CLK_PERIOD_NS;
   localparam longint CAL_PERIOD_CYCLES = CAL_PERIOD_MS * 64'd1000000 / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// *** design/fe_cfg_regs.sv ***
// Behaviour
// - Receive filter power-down bit disables and bypasses low-pass filter and coarse amp.
// - Converter power-down bit disables receive converter and fine gain amp.
// - Reference power-down bit disables internal reference; set it with external reference.
// - Interpolator power-down halts interpolators keeping contents; separate bit for DAC.
// - One bit powers down each synthesizer; its clock output goes high impedance.
// - Regulator power-down bit shuts the regulator controller off.
// - Transmit clocks from transmit synthesizer; receive clocks follow converter source.
// - Transmit multiplier code 00..11 means 1, 2, 4, 8.
// - Receive M codes 3,4,6 and N codes 2,4,1; half rate when non-multiplexed.
// - Source bit high: sample at half synthesizer rate; low takes receive clocks from transmit synthesizer.
// - Negative-edge bit makes transmit port capture on falling clock edge.
// - Cutoff is converter rate times 64 or 158 over target plus 64.
// - Filter bypass routes around the four-pole filter and powers it down.
// - Wideband selects higher cutoff and caps receive gain at 30 dB.
// - Writing one starts offset correction; bit reads one until done.
// - Read-only busy bit is high during the 500 ms filter calibration.
// - Calibrate at reset and every two seconds; disable bit; zero restarts.
// - Gain field resets to -6 dB and reads back the gain in force.
// - Gain source bit high: register sets gain; low: port lines with gain pin.
// - Gain is -6 dB plus 2 dB per code, split coarse and fine.
// - Power select pin low applies first mask, high applies second.
`default_nettype none
module fe_cfg_regs #(
   parameter longint CAL_CYCLES = fe_cfg_pkg::CAL_CYCLES,
   parameter longint CAL_PERIOD_CYCLES = fe_cfg_pkg::CAL_PERIOD_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic soft_reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic power_select_pin,
   input wire logic gain_pin,
   input wire logic [5:1] tx_port_lines,
   input wire logic rx_port_nonmux,
   input wire logic ofs_corr_done,
   output logic lpf_off,
   output logic lpf_route_around,
   output logic coarse_gain_amp_off,
   output logic converter_off,
   output logic fine_gain_amp_off,
   output logic rx_reference_off,
   output logic interp_halt,
   output logic tx_converter_off,
   output logic tx_synth_off,
   output logic rx_synth_off,
   output logic tx_clk_out_oe,
   output logic rx_clk_out_oe,
   output logic regulator_off,
   output logic rx_clk_from_tx_synth,
   output logic adc_clk_half_rx_synth,
   output logic [3:0] tx_mult_l,
   output logic [2:0] rx_mult_m,
   output logic [2:0] rx_div_n,
   output logic rx_synth_halve,
   output logic tx_capture_falling,
   output logic one_pole_en,
   output logic wideband_sel,
   output logic fast_adc_bias,
   output logic hpf_bypass,
   output logic [7:0] cutoff_num,
   output logic [8:0] cutoff_den,
   output logic lpf_cal_busy,
   output logic ofs_corr_start,
   output logic [4:0] gain_code,
   output logic signed [6:0] coarse_gain_amp_db,
   output logic signed [6:0] switched_cap_gain_amp_db,
   output logic signed [6:0] rx_gain_db
);

   if (CAL_CYCLES < 1 || CAL_CYCLES > 64'hffffffff) begin : g_chk_cal
      $error("CAL_CYCLES out of range");
   end
   if (CAL_PERIOD_CYCLES < 1 || CAL_PERIOD_CYCLES > 64'hffffffff) begin : g_chk_per
      $error("CAL_PERIOD_CYCLES out of range");
   end

   localparam logic [31:0] CAL_LAST = 32'(CAL_CYCLES - 1);
   localparam logic [31:0] PER_LAST = 32'(CAL_PERIOD_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // Decode functions

   function automatic logic [4:0] clamp_gain(input logic [4:0] c);
      clamp_gain = (c > fe_cfg_pkg::GAIN_MAX_CODE) ? fe_cfg_pkg::GAIN_MAX_CODE : c;
   endfunction

   // Returns {coarse, fine} in dB
   function automatic logic [13:0] gain_split(input logic [4:0] c, input logic wide);
      logic signed [6:0] co;
      logic signed [6:0] fi;
      logic [4:0] k;
      co = -7'sd6;
      fi = 7'sd0;
      k = clamp_gain(c);
      if (k < 5'h06) begin
         co = -7'sd6;
         fi = 7'(k) <<< 1;
      end else if (k < 5'h12) begin
         co = 7'sd0;
         if (k >= 5'h09) co = 7'sd6;
         if (k >= 5'h0c) co = 7'sd12;
         if (k >= 5'h0f) co = 7'sd18;
         case (k)
            5'h06, 5'h09, 5'h0c, 5'h0f: fi = 7'sd6;
            5'h07, 5'h0a, 5'h0d, 5'h10: fi = 7'sd8;
            default: fi = 7'sd10;
         endcase
      end else if (wide) begin
         co = 7'sd18;
         fi = 7'sd12;
      end else begin
         co = 7'sd24;
         fi = 7'sd6 + (7'(k - 5'h12) <<< 1);
      end
      gain_split = {co, fi};
   endfunction

   function automatic logic [2:0] decode_m(input logic [1:0] f);
      case (f)
         2'b00: decode_m = 3'd3;
         2'b01: decode_m = 3'd4;
         default: decode_m = 3'd6;
      endcase
   endfunction

   function automatic logic [2:0] decode_n(input logic [1:0] f);
      case (f)
         2'b00: decode_n = 3'd2;
         2'b01: decode_n = 3'd4;
         default: decode_n = 3'd1;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: three stages, change accepted when last two agree

   logic [6:0] pin_s1_r;
   logic [6:0] pin_s2_r;
   logic [6:0] pin_s3_r;
   logic [6:0] pin_f_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_r <= 7'h00;
         pin_s2_r <= 7'h00;
         pin_s3_r <= 7'h00;
         pin_f_r <= 7'h00;
      end else begin
         pin_s1_r <= {power_select_pin, gain_pin, tx_port_lines};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         for (int i = 0; i < 7; i++) begin
            if (pin_s2_r[i] == pin_s3_r[i]) pin_f_r[i] <= pin_s3_r[i];
         end
      end
   end

   logic [4:0] pin_gain_lines;
   logic pin_gain_load;
   logic pin_pwr_sel;
   assign pin_gain_lines = pin_f_r[4:0];
   assign pin_gain_load = pin_f_r[5];
   assign pin_pwr_sel = pin_f_r[6];

   ////////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, answer registered

   logic [5:0] idx;
   logic access;
   logic wr_fire;
   assign idx = paddr[7:2];
   assign access = psel && penable;
   assign wr_fire = access && pready && pwrite && pstrb[0] && !pslverr;

   logic [7:0] pd_low_r;
   logic [7:0] pd_high_r;
   logic [7:0] clk_src_r;
   logic [7:0] filt_sel_r;
   logic [7:0] tune_r;
   logic gain_src_r;
   logic [4:0] gain_code_r;
   logic ofs_busy_r;
   logic cal_busy_r;
   logic cal_dis_r;

   logic [7:0] rd_byte;
   logic unmapped;

   always_comb begin
      rd_byte = 8'h00;
      unmapped = 1'b0;
      if (paddr[1:0] != 2'b00) begin
         unmapped = 1'b1;
      end else if (idx == fe_cfg_pkg::IDX_PD_LOW) begin
         rd_byte = pd_low_r;
      end else if (idx == fe_cfg_pkg::IDX_PD_HIGH) begin
         rd_byte = pd_high_r;
      end else if (idx == fe_cfg_pkg::IDX_CLK_SRC) begin
         rd_byte = clk_src_r;
      end else if (idx == fe_cfg_pkg::IDX_FILT_SEL) begin
         rd_byte = filt_sel_r;
         rd_byte[fe_cfg_pkg::FS_OFS_CORR] = ofs_busy_r;
         rd_byte[fe_cfg_pkg::FS_CAL_BUSY] = cal_busy_r;
         rd_byte[fe_cfg_pkg::FS_CAL_DIS] = cal_dis_r;
      end else if (idx == fe_cfg_pkg::IDX_TUNE) begin
         rd_byte = tune_r;
      end else if (idx == fe_cfg_pkg::IDX_GAIN) begin
         rd_byte = {2'b00, gain_src_r, gain_code_r};
      end else begin
         unmapped = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (access && !pready) begin
         pready <= 1'b1;
         prdata <= (pwrite || unmapped) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         pslverr <= unmapped;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Plain configuration registers

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pd_low_r <= fe_cfg_pkg::RST_PD_LOW;
         pd_high_r <= fe_cfg_pkg::RST_PD_HIGH;
         clk_src_r <= fe_cfg_pkg::RST_CLK_SRC;
         filt_sel_r <= fe_cfg_pkg::RST_FILT_SEL;
         tune_r <= fe_cfg_pkg::RST_TUNE;
      end else if (soft_reset) begin
         pd_low_r <= fe_cfg_pkg::RST_PD_LOW;
         pd_high_r <= fe_cfg_pkg::RST_PD_HIGH;
         clk_src_r <= fe_cfg_pkg::RST_CLK_SRC;
         filt_sel_r <= fe_cfg_pkg::RST_FILT_SEL;
         tune_r <= fe_cfg_pkg::RST_TUNE;
      end else if (wr_fire) begin
         if (idx == fe_cfg_pkg::IDX_PD_LOW) begin
            pd_low_r <= pwdata[7:0];
         end else if (idx == fe_cfg_pkg::IDX_PD_HIGH) begin
            pd_high_r <= pwdata[7:0];
         end else if (idx == fe_cfg_pkg::IDX_CLK_SRC) begin
            clk_src_r <= pwdata[7:0];
         end else if (idx == fe_cfg_pkg::IDX_FILT_SEL) begin
            filt_sel_r <= {3'b000, pwdata[4:0]};
         end else if (idx == fe_cfg_pkg::IDX_TUNE) begin
            tune_r <= pwdata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Gain: register or pin loaded, always reads the value in force

   logic wr_gain;
   assign wr_gain = wr_fire && (idx == fe_cfg_pkg::IDX_GAIN);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gain_src_r <= fe_cfg_pkg::RST_GAIN[fe_cfg_pkg::GAIN_SRC];
         gain_code_r <= fe_cfg_pkg::RST_GAIN[4:0];
      end else if (soft_reset) begin
         gain_src_r <= fe_cfg_pkg::RST_GAIN[fe_cfg_pkg::GAIN_SRC];
         gain_code_r <= fe_cfg_pkg::RST_GAIN[4:0];
      end else if (wr_gain) begin
         gain_src_r <= pwdata[fe_cfg_pkg::GAIN_SRC];
         if (pwdata[fe_cfg_pkg::GAIN_SRC]) gain_code_r <= clamp_gain(pwdata[4:0]);
      end else if (!gain_src_r && pin_gain_load) begin
         gain_code_r <= clamp_gain(pin_gain_lines);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Offset correction: set by write wins over completion

   logic ofs_wr;
   assign ofs_wr = wr_fire && (idx == fe_cfg_pkg::IDX_FILT_SEL) && pwdata[fe_cfg_pkg::FS_OFS_CORR];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ofs_busy_r <= 1'b0;
         ofs_corr_start <= 1'b0;
      end else if (soft_reset) begin
         ofs_busy_r <= 1'b0;
         ofs_corr_start <= 1'b0;
      end else begin
         ofs_corr_start <= ofs_wr;
         if (ofs_wr) ofs_busy_r <= 1'b1;
         else if (ofs_corr_done) ofs_busy_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Filter calibration scheduler

   logic [31:0] cal_cnt_r;
   logic [31:0] per_cnt_r;
   logic cal_wr;
   logic cal_kick;
   assign cal_wr = wr_fire && (idx == fe_cfg_pkg::IDX_FILT_SEL);
   assign cal_kick = (cal_wr && !pwdata[fe_cfg_pkg::FS_CAL_DIS])
                     || (!cal_dis_r && !cal_busy_r && per_cnt_r == PER_LAST);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_dis_r <= 1'b0;
      end else if (soft_reset) begin
         cal_dis_r <= 1'b0;
      end else if (cal_wr) begin
         cal_dis_r <= pwdata[fe_cfg_pkg::FS_CAL_DIS];
      end
   end

   // Busy starts at reset, so a calibration runs right after it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_busy_r <= 1'b1;
         cal_cnt_r <= 32'h0000_0000;
      end else if (soft_reset) begin
         cal_busy_r <= 1'b1;
         cal_cnt_r <= 32'h0000_0000;
      end else if (cal_kick) begin
         cal_busy_r <= 1'b1;
         cal_cnt_r <= 32'h0000_0000;
      end else if (cal_busy_r) begin
         if (cal_cnt_r == CAL_LAST) begin
            cal_busy_r <= 1'b0;
            cal_cnt_r <= 32'h0000_0000;
         end else begin
            cal_cnt_r <= cal_cnt_r + 32'h0000_0001;
         end
      end
   end

   // Period counts from the end of one calibration to the start of the next
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         per_cnt_r <= 32'h0000_0000;
      end else if (soft_reset || cal_busy_r || cal_dis_r || cal_kick) begin
         per_cnt_r <= 32'h0000_0000;
      end else begin
         per_cnt_r <= per_cnt_r + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registered control outputs

   logic [7:0] pd_mask;
   logic [13:0] split;
   assign pd_mask = pin_pwr_sel ? pd_high_r : pd_low_r;
   assign split = gain_split(gain_code_r, filt_sel_r[fe_cfg_pkg::FS_WIDE]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lpf_off <= 1'b0;
         lpf_route_around <= 1'b0;
         coarse_gain_amp_off <= 1'b0;
         converter_off <= 1'b0;
         fine_gain_amp_off <= 1'b0;
         rx_reference_off <= 1'b0;
         interp_halt <= 1'b0;
         tx_converter_off <= 1'b0;
         tx_synth_off <= 1'b0;
         rx_synth_off <= 1'b0;
         tx_clk_out_oe <= 1'b1;
         rx_clk_out_oe <= 1'b1;
         regulator_off <= 1'b0;
      end else begin
         lpf_off <= pd_mask[fe_cfg_pkg::PD_LPF]
                    || filt_sel_r[fe_cfg_pkg::FS_BYPASS];
         lpf_route_around <= pd_mask[fe_cfg_pkg::PD_LPF]
                             || filt_sel_r[fe_cfg_pkg::FS_BYPASS];
         coarse_gain_amp_off <= pd_mask[fe_cfg_pkg::PD_LPF];
         converter_off <= pd_mask[fe_cfg_pkg::PD_ADC];
         fine_gain_amp_off <= pd_mask[fe_cfg_pkg::PD_ADC];
         rx_reference_off <= pd_mask[fe_cfg_pkg::PD_REF];
         interp_halt <= pd_mask[fe_cfg_pkg::PD_INTERP];
         tx_converter_off <= pd_mask[fe_cfg_pkg::PD_DAC];
         tx_synth_off <= pd_mask[fe_cfg_pkg::PD_TX_SYN];
         rx_synth_off <= pd_mask[fe_cfg_pkg::PD_RX_SYN];
         tx_clk_out_oe <= !pd_mask[fe_cfg_pkg::PD_TX_SYN];
         rx_clk_out_oe <= !pd_mask[fe_cfg_pkg::PD_RX_SYN];
         regulator_off <= pd_mask[fe_cfg_pkg::PD_REG];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_clk_from_tx_synth <= 1'b1;
         adc_clk_half_rx_synth <= 1'b0;
         tx_mult_l <= 4'h1;
         rx_mult_m <= 3'd3;
         rx_div_n <= 3'd2;
         rx_synth_halve <= 1'b0;
         tx_capture_falling <= 1'b0;
      end else begin
         rx_clk_from_tx_synth <= !clk_src_r[fe_cfg_pkg::CS_ADC_SRC];
         adc_clk_half_rx_synth <= clk_src_r[fe_cfg_pkg::CS_ADC_SRC];
         tx_mult_l <= 4'h1 << clk_src_r[fe_cfg_pkg::CS_L_LO +: 2];
         rx_mult_m <= decode_m(clk_src_r[fe_cfg_pkg::CS_M_LO +: 2]);
         rx_div_n <= decode_n(clk_src_r[fe_cfg_pkg::CS_N_LO +: 2]);
         rx_synth_halve <= rx_port_nonmux;
         tx_capture_falling <= clk_src_r[fe_cfg_pkg::CS_NEG_EDGE];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         one_pole_en <= 1'b0;
         wideband_sel <= 1'b0;
         fast_adc_bias <= 1'b0;
         hpf_bypass <= 1'b0;
         cutoff_num <= fe_cfg_pkg::CUT_NUM_LOW;
         cutoff_den <= fe_cfg_pkg::TARGET_OFS;
         lpf_cal_busy <= 1'b0;
         gain_code <= 5'h00;
         coarse_gain_amp_db <= -7'sd6;
         switched_cap_gain_amp_db <= 7'sd0;
         rx_gain_db <= -7'sd6;
      end else begin
         one_pole_en <= filt_sel_r[fe_cfg_pkg::FS_ONE_POLE];
         wideband_sel <= filt_sel_r[fe_cfg_pkg::FS_WIDE];
         fast_adc_bias <= filt_sel_r[fe_cfg_pkg::FS_FAST_ADC];
         hpf_bypass <= filt_sel_r[fe_cfg_pkg::FS_HPF_BYP];
         cutoff_num <= filt_sel_r[fe_cfg_pkg::FS_WIDE] ? fe_cfg_pkg::CUT_NUM_HIGH
                                                      : fe_cfg_pkg::CUT_NUM_LOW;
         cutoff_den <= {1'b0, tune_r} + fe_cfg_pkg::TARGET_OFS;
         lpf_cal_busy <= cal_busy_r;
         gain_code <= gain_code_r;
         coarse_gain_amp_db <= split[13:7];
         switched_cap_gain_amp_db <= split[6:0];
         rx_gain_db <= $signed(split[13:7]) + $signed(split[6:0]);
      end
   end

endmodule
`default_nettype wire

// *** sim/fe_cfg_regs_checker.sv ***
`default_nettype none
module fe_cfg_regs_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic lpf_off,
   input wire logic coarse_gain_amp_off,
   input wire logic converter_off,
   input wire logic fine_gain_amp_off,
   input wire logic tx_synth_off,
   input wire logic rx_synth_off,
   input wire logic tx_clk_out_oe,
   input wire logic rx_clk_out_oe,
   input wire logic [3:0] tx_mult_l,
   input wire logic [2:0] rx_mult_m,
   input wire logic [2:0] rx_div_n,
   input wire logic tx_capture_falling,
   input wire logic wideband_sel,
   input wire logic [7:0] cutoff_num,
   input wire logic ofs_corr_start,
   input wire logic [4:0] gain_code,
   input wire logic signed [6:0] coarse_gain_amp_db,
   input wire logic signed [6:0] switched_cap_gain_amp_db,
   input wire logic signed [6:0] rx_gain_db
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr_ok;
   // Accepted write at the completing edge
   assign wr_ok = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
   a_ready_single: assert property (pready |=> !pready) else $error("pready held");
   a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
   a_coarse_lpf: assert property (coarse_gain_amp_off |-> lpf_off) else $error("lpf on");
   a_conv_fine: assert property (converter_off == fine_gain_amp_off) else $error("fine amp");
   a_tx_clk_hiz: assert property (tx_synth_off != tx_clk_out_oe) else $error("tx clk oe");
   a_rx_clk_hiz: assert property (rx_synth_off != rx_clk_out_oe) else $error("rx clk oe");
   a_tx_mult_code: assert property (tx_mult_l inside {4'h1, 4'h2, 4'h4, 4'h8})
      else $error("bad L");
   a_rx_ratio_legal: assert property (rx_mult_m inside {3'h3, 3'h4, 3'h6}
      && rx_div_n inside {3'h1, 3'h2, 3'h4}) else $error("bad M or N");
   a_cutoff_num: assert property (cutoff_num == (wideband_sel ? 8'd158 : 8'd64))
      else $error("cutoff numerator");
   a_gain_split: assert property (rx_gain_db == coarse_gain_amp_db + switched_cap_gain_amp_db)
      else $error("gain split");
   a_gain_map: assert property ((gain_code <= 5'h11 || !wideband_sel) |->
      rx_gain_db == $signed({1'b0, gain_code, 1'b0}) - 7'sd6) else $error("gain map");
   a_wide_cap: assert property (wideband_sel |-> rx_gain_db <= 7'sd30) else $error("cap");
   a_ofs_pulse: assert property (ofs_corr_start |=> !ofs_corr_start) else $error("ofs");
   a_ofs_start: assert property (wr_ok && paddr == 8'h10 && pwdata[5] |-> ##[1:2] ofs_corr_start)
      else $error("no offset start");
   a_neg_edge: assert property (wr_ok && paddr == 8'h0c |->
      ##2 tx_capture_falling == $past(pwdata[7], 2)) else $error("edge select");
endmodule
bind fe_cfg_regs fe_cfg_regs_checker u_fe_cfg_regs_checker (.*);
`default_nettype wire

// *** sim/modem_front_end_config_regs_bench.sv ***
`default_nettype none
module modem_front_end_config_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, soft_reset, psel, penable, pwrite, power_select_pin, gain_pin, s, er;
   logic rx_port_nonmux, ofs_corr_done, pready, pslverr, lpf_off, lpf_route_around;
   logic coarse_gain_amp_off, converter_off, fine_gain_amp_off, rx_reference_off;
   logic interp_halt, tx_converter_off, tx_synth_off, rx_synth_off, tx_clk_out_oe;
   logic rx_clk_out_oe, regulator_off, rx_clk_from_tx_synth, adc_clk_half_rx_synth;
   logic rx_synth_halve, tx_capture_falling, one_pole_en, wideband_sel, fast_adc_bias;
   logic hpf_bypass, lpf_cal_busy, ofs_corr_start;
   logic [7:0] paddr, cutoff_num, pd_vec, v;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, tx_mult_l;
   logic [5:1] tx_port_lines;
   logic [2:0] rx_mult_m, rx_div_n;
   logic [8:0] cutoff_den;
   logic [4:0] gain_code, c;
   logic signed [6:0] coarse_gain_amp_db, switched_cap_gain_amp_db, rx_gain_db, db;
   int fail_count, n_tests;
   logic [7:0] addrs [6] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
   logic [7:0] rsts [6] = '{fe_cfg_pkg::RST_PD_LOW, fe_cfg_pkg::RST_PD_HIGH,
      fe_cfg_pkg::RST_CLK_SRC, fe_cfg_pkg::RST_FILT_SEL, fe_cfg_pkg::RST_TUNE,
      fe_cfg_pkg::RST_GAIN};
   logic [2:0] mt [4] = '{3'h3, 3'h4, 3'h6, 3'h6};
   logic [2:0] nt [4] = '{3'h2, 3'h4, 3'h1, 3'h1};
   logic [4:0] codes [6] = '{5'h00, 5'h05, 5'h06, 5'h12, 5'h15, 5'h1f};
   assign pd_vec = {regulator_off, rx_synth_off, tx_synth_off, tx_converter_off,
      interp_halt, rx_reference_off, converter_off, coarse_gain_amp_off};
   fe_cfg_regs #(.CAL_CYCLES(20), .CAL_PERIOD_CYCLES(50)) u_fe_cfg_regs (.*);
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   ////////////////////////////////////////
   task automatic tally_and_finish();
      if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail_count++;
         tally_and_finish();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   ////////////////////////////////////////
   initial begin
      {presetn, soft_reset, psel, penable, pwrite, power_select_pin, gain_pin} = '0;
      {rx_port_nonmux, ofs_corr_done, paddr, pwdata, tx_port_lines} = '0;
      pstrb = 4'hf;
      fail_count = 0;
      n_tests = 0;
      tick(8);
      presetn <= 1'b1;
      tick(2);
      chk(lpf_cal_busy, 1);
      chk(rx_gain_db, 7'sh7a);
      foreach (addrs[i]) begin
         apb(0, addrs[i], 0);
         chk(rd & 32'hbf, rsts[i]);
      end
      apb(0, 8'h1c, 0);
      chk(er, 1);
      apb(1, 8'h10, 8'h80);
      tick(80);
      chk(lpf_cal_busy, 0);
      apb(1, 8'h10, 8'hc0);
      apb(0, 8'h10, 0);
      chk(rd, 32'h80);
      apb(1, 8'h10, 8'h00);
      tick(2);
      chk(lpf_cal_busy, 1);
      apb(0, 8'h10, 0);
      chk(rd, 32'h40);
      tick(30);
      chk(lpf_cal_busy, 0);
      apb(1, 8'h10, 8'ha0);
      apb(0, 8'h10, 0);
      chk(rd, 32'ha0);
      ofs_corr_done <= 1'b1;
      tick(1);
      ofs_corr_done <= 1'b0;
      tick(2);
      apb(0, 8'h10, 0);
      chk(rd, 32'h80);
      apb(1, 8'h04, 8'h55);
      apb(1, 8'h08, 8'haa);
      tick(2);
      chk(pd_vec, 8'h55);
      power_select_pin <= 1'b1;
      tick(8);
      chk(pd_vec, 8'haa);
      chk({tx_clk_out_oe, rx_clk_out_oe}, 2'b01);
      power_select_pin <= 1'b0;
      apb(1, 8'h04, 8'h00);
      apb(1, 8'h10, 8'h81);
      tick(2);
      chk({lpf_off, lpf_route_around, coarse_gain_amp_off}, 3'b110);
      for (int i = 0; i < 4; i++) begin
         c = 5'(i);
         s = (i != 2);
         v = {c[0], s, c[1:0], c[1:0], c[1:0]};
         apb(1, 8'h0c, v);
         tick(2);
         chk({tx_mult_l, rx_mult_m, rx_div_n}, {4'h1 << i, mt[i], nt[i]});
         chk({tx_capture_falling, adc_clk_half_rx_synth, rx_clk_from_tx_synth}, {c[0], s, !s});
         apb(0, 8'h0c, 0);
         chk(rd, v);
      end
      apb(1, 8'h14, 8'h20);
      apb(1, 8'h10, 8'h9e);
      tick(2);
      chk({one_pole_en, wideband_sel, fast_adc_bias, hpf_bypass, cutoff_num, cutoff_den},
         {4'hf, 8'd158, 9'h060});
      chk(lpf_off, 0);
      for (int w = 1; w >= 0; w--) begin
         apb(1, 8'h10, (w != 0) ? 8'h84 : 8'h80);
         foreach (codes[k]) begin
            c = (codes[k] > 5'h15) ? 5'h15 : codes[k];
            db = $signed({1'b0, c, 1'b0}) - 7'sd6;
            if (w != 0 && db > 7'sd30) db = 7'sd30;
            apb(1, 8'h18, {3'b001, codes[k]});
            tick(2);
            chk(rx_gain_db, db);
            apb(0, 8'h18, 0);
            chk(rd, {3'b001, c});
         end
      end
      apb(1, 8'h18, 8'h00);
      tx_port_lines <= 5'h0b;
      gain_pin <= 1'b1;
      tick(8);
      gain_pin <= 1'b0;
      tick(2);
      apb(0, 8'h18, 0);
      chk(rd, 32'h0b);
      chk(rx_gain_db, 7'sd16);
      apb(1, 8'h18, 8'h21);
      tx_port_lines <= 5'h11;
      gain_pin <= 1'b1;
      tick(8);
      apb(0, 8'h18, 0);
      chk(rd, 32'h21);
      gain_pin <= 1'b0;
      rx_port_nonmux <= 1'b1;
      tick(8);
      chk(rx_synth_halve, 1);
      soft_reset <= 1'b1;
      tick(1);
      soft_reset <= 1'b0;
      tick(1);
      apb(0, 8'h18, 0);
      chk(rd, 32'h00);
      tally_and_finish();
   end
endmodule
`default_nettype wire
